// File: hdl/eeprom_cmd_pkg.sv
// Function
// RQ1: Code 111 reloads; 100, 101, 110 rejected.
// RQ2: Read fetches byte into data register.
// RQ3: Write sends data register byte to address.
// RQ4: Reload fails unless first byte is A5h.
// RQ5: Reload drops ready; software polls ready flag.
// RQ6: Read-only bit 18 flags loader past end.
// RQ7: Write without response in 30 ms aborts.
// RQ8: Nack, stretch, bus wait, bad code: timeout.
// RQ9: Timeout and loaded flags clear on one.
// RQ10: Loaded flag set on good load, cleared at reload.
// RQ11: 16-bit address field, reset zero, byte aligned.
// RQ12: Busy bit starts command; stays set while working.
// RQ13: Busy clears on completion or timeout.
// RQ14: Read timeout leaves data register unchanged.
package eeprom_cmd_pkg;
    localparam int REG_AW = 12;
    localparam logic [11:0] OFF_HARDWARE_CONFIG_REG = 12'h074;
    localparam logic [11:0] OFF_CMD = 12'h1B4;
    localparam logic [11:0] OFF_DATA = 12'h1B8;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h1C0;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h1C4;

    localparam int CMD_BUSY_BIT = 31;
    localparam int CMD_CODE_LSB = 28;
    localparam int CMD_PAST_END_BIT = 18;
    localparam int CMD_TMO_BIT = 17;
    localparam int CMD_LOADED_BIT = 16;
    localparam int HW_READY_BIT = 0;

    localparam logic [2:0] CODE_READ = 3'h0;
    localparam logic [2:0] CODE_WRITE = 3'h3;
    localparam logic [2:0] CODE_RELOAD = 3'h7;

    localparam logic [7:0] SIGNATURE = 8'hA5;
    localparam logic [15:0] SIG_ADDR = 16'h0000;
    localparam logic [15:0] LEN_ADDR = 16'h0001;
    localparam logic [15:0] BODY_ADDR = 16'h0002;
    localparam logic [15:0] EE_LAST_ADDR_DEF = 16'h07FF;

    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] CODE_RST = 3'h0;

    localparam int IRQ_DONE = 0;
    localparam int IRQ_TMO = 1;
    localparam int IRQ_LOADED = 2;
    localparam int IRQ_PAST_END = 3;
    localparam int IRQ_W = 4;

    localparam int CLK_MHZ = 100;
    localparam int RESP_TMO_MS = 30;
    localparam int STRETCH_TMO_MS = 30;
    // 1.92 s
    localparam int BUS_ACQ_MS = 1920;
    localparam int RESP_TMO_CYC = RESP_TMO_MS * 1000 * CLK_MHZ;
    localparam int STRETCH_TMO_CYC = STRETCH_TMO_MS * 1000 * CLK_MHZ;
    localparam int BUS_ACQ_CYC = BUS_ACQ_MS * 1000 * CLK_MHZ;
    localparam int TMR_W = 28;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_XFER = 2'b11
    } ctrl_state_t;

    typedef enum logic [1:0] {
        PH_SIG = 2'b00,
        PH_LEN = 2'b01,
        PH_BODY = 2'b11
    } load_phase_t;
endpackage

// File: hdl/op_timer_if.sv
`timescale 1ns/1ps
interface op_timer_if #(parameter int W = 28);
    logic clear;
    logic run;
    logic [W-1:0] limit;
    logic expired;
    modport ctrl (output clear, output run, output limit, input expired);
    modport timer (input clear, input run, input limit, output expired);
endinterface

// File: hdl/op_timer.sv
`timescale 1ns/1ps
module op_timer #(
    parameter int W = 28
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    op_timer_if.timer tmr
);
    logic [W-1:0] cnt_r;

    // Saturates at the limit so a late clear never sees a wrapped count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            if (tmr.clear) begin
                cnt_r <= '0;
            end else if (tmr.run && !tmr.expired) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign tmr.expired = tmr.run && (cnt_r >= tmr.limit);
endmodule

// File: hdl/serial_eeprom_command_ctrl.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module serial_eeprom_command_ctrl #(
    parameter int RESP_TMO_CYC = eeprom_cmd_pkg::RESP_TMO_CYC,
    parameter int STRETCH_TMO_CYC = eeprom_cmd_pkg::STRETCH_TMO_CYC,
    parameter int BUS_ACQ_CYC = eeprom_cmd_pkg::BUS_ACQ_CYC,
    parameter logic [15:0] EE_LAST_ADDR = eeprom_cmd_pkg::EE_LAST_ADDR_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic device_ready,
    output logic xfer_req,
    output logic xfer_write,
    output logic [15:0] xfer_addr,
    output logic [7:0] xfer_wdata,
    input wire logic bus_free,
    input wire logic xfer_done,
    input wire logic xfer_nack,
    input wire logic [7:0] xfer_rdata,
    input wire logic scl_held_low,
    output logic [7:0] cfg_byte,
    output logic cfg_valid
);
    localparam int TW = eeprom_cmd_pkg::TMR_W;

    eeprom_cmd_pkg::ctrl_state_t state_r;
    eeprom_cmd_pkg::load_phase_t phase_r;
    logic [2:0] code_r;
    logic [15:0] addr_r;
    logic [15:0] ptr_r;
    logic [7:0] data_r;
    logic [7:0] remain_r;
    logic ready_r;
    logic loaded_r;
    logic tmo_r;
    logic past_r;
    logic [eeprom_cmd_pkg::IRQ_W-1:0] istat_r;
    logic [eeprom_cmd_pkg::IRQ_W-1:0] imask_r;
    logic [eeprom_cmd_pkg::IRQ_W-1:0] ievt;
    logic [7:0] cfg_byte_r;
    logic cfg_valid_r;
    logic [31:0] rdata_r;

    logic wr_cmd;
    logic wr_data;
    logic idle;
    logic [2:0] code_w;
    logic code_ok;
    logic start_ok;
    logic start_bad;
    logic is_reload;
    logic good;
    logic abort;
    logic cont;
    logic finish;
    logic load_ok;
    logic past_evt;
    logic beyond;
    logic [16:0] nxt_ptr17;

    op_timer_if #(.W(TW)) wt_if ();
    op_timer_if #(.W(TW)) st_if ();

    assign idle = (state_r == eeprom_cmd_pkg::ST_IDLE);
    assign wr_cmd = reg_wr && (reg_addr == eeprom_cmd_pkg::OFF_CMD);
    assign wr_data = reg_wr && (reg_addr == eeprom_cmd_pkg::OFF_DATA);
    assign code_w = reg_wdata[eeprom_cmd_pkg::CMD_CODE_LSB +: 3];
    assign code_ok = (code_w == eeprom_cmd_pkg::CODE_READ) || (code_w == eeprom_cmd_pkg::CODE_WRITE)
        || (code_w == eeprom_cmd_pkg::CODE_RELOAD); // RQ1
    // Commands written while busy are ignored rather than queued
    assign start_ok = wr_cmd && idle && reg_wdata[eeprom_cmd_pkg::CMD_BUSY_BIT] && code_ok; // RQ12
    assign start_bad = wr_cmd && idle && reg_wdata[eeprom_cmd_pkg::CMD_BUSY_BIT] && !code_ok; // RQ1 RQ8
    assign is_reload = (code_r == eeprom_cmd_pkg::CODE_RELOAD);

    // Wait timer: bus acquisition in ACQ, response in XFER
    assign wt_if.clear = idle || xfer_req || good;
    assign wt_if.run = !idle;
    assign wt_if.limit = (state_r == eeprom_cmd_pkg::ST_ACQ) ? TW'(BUS_ACQ_CYC) : TW'(RESP_TMO_CYC); // RQ7 RQ8
    assign st_if.clear = !scl_held_low;
    assign st_if.run = scl_held_low && (state_r == eeprom_cmd_pkg::ST_XFER);
    assign st_if.limit = TW'(STRETCH_TMO_CYC); // RQ8

    op_timer #(.W(TW)) u_wait_tmr (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .tmr(wt_if.timer)
    );

    op_timer #(.W(TW)) u_stretch_tmr (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .tmr(st_if.timer)
    );

    assign good = (state_r == eeprom_cmd_pkg::ST_XFER) && xfer_done && !xfer_nack;
    // A byte that lands in the expiry cycle still counts as done
    assign abort = !good && (((state_r == eeprom_cmd_pkg::ST_ACQ) && !bus_free && wt_if.expired)
        || ((state_r == eeprom_cmd_pkg::ST_XFER) && (wt_if.expired || st_if.expired || xfer_done))); // RQ7 RQ8

    assign nxt_ptr17 = (phase_r == eeprom_cmd_pkg::PH_LEN) ? {1'b0, eeprom_cmd_pkg::BODY_ADDR} : {1'b0, ptr_r} + 17'h00001;
    assign beyond = nxt_ptr17 > {1'b0, EE_LAST_ADDR};

    always_comb begin
        cont = 1'b0;
        load_ok = 1'b0;
        past_evt = 1'b0;
        if (good && is_reload) begin
            unique case (phase_r)
                eeprom_cmd_pkg::PH_SIG: cont = (xfer_rdata == eeprom_cmd_pkg::SIGNATURE); // RQ4
                eeprom_cmd_pkg::PH_LEN: begin
                    if (xfer_rdata == 8'h00) begin
                        load_ok = 1'b1;
                    end else begin
                        past_evt = beyond; // RQ6
                        cont = !beyond;
                    end
                end
                eeprom_cmd_pkg::PH_BODY: begin
                    if (remain_r == 8'h01) begin
                        load_ok = 1'b1;
                    end else begin
                        past_evt = beyond; // RQ6
                        cont = !beyond;
                    end
                end
                default: cont = 1'b0;
            endcase
        end
    end

    assign finish = abort || (good && !cont); // RQ13

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= eeprom_cmd_pkg::ST_IDLE;
        end else if (clk_en) begin
            unique case (state_r)
                eeprom_cmd_pkg::ST_IDLE: if (start_ok) state_r <= eeprom_cmd_pkg::ST_ACQ; // RQ12
                eeprom_cmd_pkg::ST_ACQ: begin
                    if (bus_free) begin
                        state_r <= eeprom_cmd_pkg::ST_XFER;
                    end else if (abort) begin
                        state_r <= eeprom_cmd_pkg::ST_IDLE; // RQ8
                    end
                end
                eeprom_cmd_pkg::ST_XFER: begin
                    if (finish) begin
                        state_r <= eeprom_cmd_pkg::ST_IDLE; // RQ7 RQ13
                    end else if (cont) begin
                        state_r <= eeprom_cmd_pkg::ST_ACQ;
                    end
                end
                default: state_r <= eeprom_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    // Address and code fields are writable only while idle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r <= eeprom_cmd_pkg::ADDR_RST;
            code_r <= eeprom_cmd_pkg::CODE_RST;
        end else if (clk_en && wr_cmd && idle) begin
            addr_r <= reg_wdata[15:0]; // RQ11
            code_r <= code_w;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_r <= eeprom_cmd_pkg::ADDR_RST;
            phase_r <= eeprom_cmd_pkg::PH_SIG;
            remain_r <= 8'h00;
        end else if (clk_en) begin
            if (start_ok) begin
                ptr_r <= (code_w == eeprom_cmd_pkg::CODE_RELOAD) ? eeprom_cmd_pkg::SIG_ADDR : reg_wdata[15:0];
                phase_r <= eeprom_cmd_pkg::PH_SIG;
            end else if (cont) begin
                ptr_r <= (phase_r == eeprom_cmd_pkg::PH_SIG) ? eeprom_cmd_pkg::LEN_ADDR : nxt_ptr17[15:0];
                phase_r <= (phase_r == eeprom_cmd_pkg::PH_SIG) ? eeprom_cmd_pkg::PH_LEN : eeprom_cmd_pkg::PH_BODY;
                remain_r <= (phase_r == eeprom_cmd_pkg::PH_LEN) ? xfer_rdata : remain_r - 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_r <= eeprom_cmd_pkg::DATA_RST;
        end else if (clk_en) begin
            if (good && (code_r == eeprom_cmd_pkg::CODE_READ)) begin
                data_r <= xfer_rdata; // RQ2 RQ14
            end else if (wr_data && idle) begin
                data_r <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_byte_r <= 8'h00;
            cfg_valid_r <= 1'b0;
        end else if (clk_en) begin
            cfg_valid_r <= good && is_reload && (phase_r == eeprom_cmd_pkg::PH_BODY);
            if (good && is_reload && (phase_r == eeprom_cmd_pkg::PH_BODY)) begin
                cfg_byte_r <= xfer_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_r <= 1'b1;
        end else if (clk_en) begin
            if (start_ok && (code_w == eeprom_cmd_pkg::CODE_RELOAD)) begin
                ready_r <= 1'b0; // RQ5
            end else if (finish && is_reload) begin
                ready_r <= 1'b1; // RQ5
            end
        end
    end

    // Hardware set wins over a same-cycle write-one clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmo_r <= 1'b0;
            loaded_r <= 1'b0;
            past_r <= 1'b0;
        end else if (clk_en) begin
            if (abort || start_bad) begin
                tmo_r <= 1'b1; // RQ7 RQ8
            end else if (wr_cmd && reg_wdata[eeprom_cmd_pkg::CMD_TMO_BIT]) begin
                tmo_r <= 1'b0; // RQ9
            end
            if (load_ok) begin
                loaded_r <= 1'b1; // RQ10
            end else if (start_ok && (code_w == eeprom_cmd_pkg::CODE_RELOAD)) begin
                loaded_r <= 1'b0; // RQ10
            end else if (wr_cmd && reg_wdata[eeprom_cmd_pkg::CMD_LOADED_BIT]) begin
                loaded_r <= 1'b0; // RQ9
            end
            if (past_evt) begin
                past_r <= 1'b1; // RQ6
            end else if (start_ok && (code_w == eeprom_cmd_pkg::CODE_RELOAD)) begin
                past_r <= 1'b0;
            end
        end
    end

    always_comb begin
        ievt = '0;
        ievt[eeprom_cmd_pkg::IRQ_DONE] = finish || start_bad;
        ievt[eeprom_cmd_pkg::IRQ_TMO] = abort || start_bad;
        ievt[eeprom_cmd_pkg::IRQ_LOADED] = load_ok;
        ievt[eeprom_cmd_pkg::IRQ_PAST_END] = past_evt;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            istat_r <= '0;
            imask_r <= '0;
        end else if (clk_en) begin
            if (reg_wr && (reg_addr == eeprom_cmd_pkg::OFF_IRQ_STAT)) begin
                istat_r <= (istat_r & ~reg_wdata[eeprom_cmd_pkg::IRQ_W-1:0]) | ievt;
            end else begin
                istat_r <= istat_r | ievt;
            end
            if (reg_wr && (reg_addr == eeprom_cmd_pkg::OFF_IRQ_MASK)) begin
                imask_r <= reg_wdata[eeprom_cmd_pkg::IRQ_W-1:0];
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h00000000;
        end else if (clk_en) begin
            rdata_r <= 32'h00000000;
            if (reg_rd) begin
                unique case (reg_addr)
                    eeprom_cmd_pkg::OFF_CMD: rdata_r <= {!idle, code_r, 9'h000, past_r, tmo_r, loaded_r, addr_r};
                    eeprom_cmd_pkg::OFF_DATA: rdata_r <= {24'h000000, data_r};
                    eeprom_cmd_pkg::OFF_HARDWARE_CONFIG_REG: rdata_r <= {31'h00000000, ready_r};
                    eeprom_cmd_pkg::OFF_IRQ_STAT: rdata_r <= {28'h0000000, istat_r};
                    eeprom_cmd_pkg::OFF_IRQ_MASK: rdata_r <= {28'h0000000, imask_r};
                    default: rdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = |(istat_r & imask_r);
    assign device_ready = ready_r;
    assign xfer_req = clk_en && (state_r == eeprom_cmd_pkg::ST_ACQ) && bus_free;
    assign xfer_write = (code_r == eeprom_cmd_pkg::CODE_WRITE);
    assign xfer_addr = ptr_r; // RQ3
    assign xfer_wdata = data_r; // RQ3
    assign cfg_byte = cfg_byte_r;
    assign cfg_valid = cfg_valid_r;

    default clocking cb @(posedge ref_clk iff clk_en);
    endclocking
    default disable iff (!rst_b);

    sequence s_reload_start;
        start_ok && (code_w == eeprom_cmd_pkg::CODE_RELOAD);
    endsequence

    sequence s_sig_bad;
        good && is_reload && (phase_r == eeprom_cmd_pkg::PH_SIG) && (xfer_rdata != eeprom_cmd_pkg::SIGNATURE);
    endsequence

    bad_code_a: assert property (start_bad |=> idle && tmo_r) // RQ1
        else $error("reserved code did not time out");
    read_data_a: assert property (good && (code_r == eeprom_cmd_pkg::CODE_READ) |=> data_r == $past(xfer_rdata)) // RQ2
        else $error("read byte not stored");
    write_src_a: assert property (xfer_req && xfer_write |-> xfer_wdata == data_r && xfer_addr == addr_r // RQ3
        && !idle)
        else $error("write byte or location not from registers");
    sig_check_a: assert property (s_sig_bad |=> idle && ready_r && !loaded_r) // RQ4
        else $error("bad signature did not fail reload");
    ready_drop_a: assert property (s_reload_start |=> !ready_r ##1 !ready_r [*1]) // RQ5
        else $error("ready stayed high after reload start");
    past_end_a: assert property ($rose(past_r) |-> $past(is_reload) && idle) // RQ6
        else $error("past-end flag without loader overrun");
    resp_tmo_a: assert property ((state_r == eeprom_cmd_pkg::ST_XFER) && wt_if.expired && !xfer_done |=> idle && tmo_r) // RQ7
        else $error("response timeout not taken");
    nack_tmo_a: assert property (abort |=> tmo_r && idle) // RQ8
        else $error("abort did not set timeout");
    w1c_hold_a: assert property (wr_cmd && !reg_wdata[eeprom_cmd_pkg::CMD_TMO_BIT] && tmo_r |=> tmo_r) // RQ9
        else $error("timeout flag cleared by zero");
    load_clr_a: assert property (s_reload_start |=> !loaded_r) // RQ10
        else $error("loaded flag not cleared at reload");
    busy_end_a: assert property (finish |=> idle) // RQ13
        else $error("busy not cleared on completion");
endmodule

// File: tb/eeprom_engine_model.sv
`timescale 1ns/1ps
module eeprom_engine_model (
    input wire logic ref_clk,
    input wire logic xfer_req,
    input wire logic xfer_write,
    input wire logic [15:0] xfer_addr,
    input wire logic [7:0] xfer_wdata,
    output logic bus_free,
    output logic xfer_done,
    output logic xfer_nack,
    output logic [7:0] xfer_rdata,
    output logic scl_held_low
);
    logic [7:0] mem [0:255];
    logic wr_en = 1'b1;
    logic mute = 1'b0;
    logic nack = 1'b0;
    logic hog = 1'b0;
    logic stretch = 1'b0;
    int lat = 2;
    int cnt = 0;
    logic [7:0] last_q = 8'h00;
    initial xfer_done = 1'b0;
    assign bus_free = ~hog;
    assign scl_held_low = stretch;
    assign xfer_nack = xfer_done & nack;
    // Outside a reply the data bits show junk, not the last byte
    assign xfer_rdata = xfer_done ? mem[xfer_addr[7:0]] : ~last_q;
    always @(posedge ref_clk) begin
        xfer_done <= 1'b0;
        if (xfer_req === 1'b1 && !mute) begin
            cnt <= lat;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        if (cnt == 1) begin
            xfer_done <= 1'b1;
            last_q <= mem[xfer_addr[7:0]];
            if (xfer_write && wr_en && !nack) begin
                mem[xfer_addr[7:0]] <= xfer_wdata;
            end
        end
    end
endmodule

// File: tb/serial_eeprom_command_ctrl_tb_top.sv
`timescale 1ns/1ps
module serial_eeprom_command_ctrl_tb_top;
    typedef struct packed {logic w; logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq, device_ready, xfer_req, xfer_write, cfg_valid;
    logic bus_free, xfer_done, xfer_nack, scl_held_low;
    logic [15:0] xfer_addr;
    logic [7:0] xfer_wdata, xfer_rdata, cfg_byte;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] cfg_q[$];
    logic [31:0] v;
    logic [2:0] bad[5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    row_t rows[5] = '{'{1'b1, 16'h0005, 8'h3C, 8'h3C}, '{1'b0, 16'h0005, 8'h00, 8'h3C},
        '{1'b1, 16'h000A, 8'hC3, 8'hC3}, '{1'b0, 16'h000A, 8'h00, 8'hC3}, '{1'b0, 16'h0007, 8'h00, 8'h5A}};

    always #5 ref_clk = ~ref_clk;

    serial_eeprom_command_ctrl #(.RESP_TMO_CYC(40), .STRETCH_TMO_CYC(20), .BUS_ACQ_CYC(50),
        .EE_LAST_ADDR(16'h000F)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .device_ready(device_ready), .xfer_req(xfer_req),
        .xfer_write(xfer_write), .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata),
        .bus_free(bus_free), .xfer_done(xfer_done), .xfer_nack(xfer_nack),
        .xfer_rdata(xfer_rdata), .scl_held_low(scl_held_low), .cfg_byte(cfg_byte),
        .cfg_valid(cfg_valid));

    eeprom_engine_model u_eep (.ref_clk(ref_clk), .xfer_req(xfer_req), .xfer_write(xfer_write),
        .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .bus_free(bus_free),
        .xfer_done(xfer_done), .xfer_nack(xfer_nack), .xfer_rdata(xfer_rdata),
        .scl_held_low(scl_held_low));

    task automatic end_sim();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic cmd(input logic [2:0] c, input logic [15:0] a);
        wr(eeprom_cmd_pkg::OFF_CMD, {1'b1, c, 12'h000, a});
    endtask

    // Bounded poll so a stuck flag ends in a mismatch, not a hang
    task automatic wait_bit(input logic [11:0] a, input int b, input logic want);
        int n;
        n = 0;
        rd(a, v);
        while (v[b] !== want && n < 300) begin
            rd(a, v);
            n++;
        end
        chk({31'h0, v[b]}, {31'h0, want});
    endtask

    always @(posedge ref_clk) begin
        if (cfg_valid === 1'b1) begin
            cfg_q.push_back(cfg_byte);
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        u_eep.mem[7] = 8'h5A;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(eeprom_cmd_pkg::OFF_CMD, v);
        chk(v, 32'h0);
        rd(eeprom_cmd_pkg::OFF_HARDWARE_CONFIG_REG, v);
        chk(v, 32'h1);
        rd(eeprom_cmd_pkg::OFF_DATA, v);
        chk(v, 32'h0);
        rd(12'h100, v);
        chk(v, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(eeprom_cmd_pkg::OFF_DATA, {24'h0, rows[i].d});
            end
            cmd(rows[i].w ? eeprom_cmd_pkg::CODE_WRITE : eeprom_cmd_pkg::CODE_READ, rows[i].a);
            wait_bit(eeprom_cmd_pkg::OFF_CMD, 31, 1'b0);
            chk(v & 32'h0002_FFFF, {16'h0, rows[i].a});
            rd(eeprom_cmd_pkg::OFF_DATA, v);
            chk(v, {24'h0, rows[i].e});
            chk({24'h0, u_eep.mem[rows[i].a[7:0]]}, {24'h0, rows[i].e});
        end
        foreach (bad[i]) begin
            cmd(bad[i], 16'h0000);
            rd(eeprom_cmd_pkg::OFF_CMD, v);
            chk(v & 32'h8002_0000, 32'h0002_0000);
            wr(eeprom_cmd_pkg::OFF_CMD, 32'h0);
            rd(eeprom_cmd_pkg::OFF_CMD, v);
            chk(v & 32'h0002_0000, 32'h0002_0000);
            wr(eeprom_cmd_pkg::OFF_CMD, 32'h0002_0000);
            rd(eeprom_cmd_pkg::OFF_CMD, v);
            chk(v & 32'h0002_0000, 32'h0);
        end
        // Nack, silent write, bus never free, clock stretched
        for (int k = 0; k < 4; k++) begin
            u_eep.nack = (k == 0);
            u_eep.mute = (k == 1 || k == 3);
            u_eep.hog = (k == 2);
            u_eep.stretch = (k == 3);
            cmd((k == 1) ? eeprom_cmd_pkg::CODE_WRITE : eeprom_cmd_pkg::CODE_READ, 16'h0005);
            wait_bit(eeprom_cmd_pkg::OFF_CMD, 31, 1'b0);
            chk(v & 32'h0002_0000, 32'h0002_0000);
            rd(eeprom_cmd_pkg::OFF_DATA, v);
            chk(v, 32'h5A);
            wr(eeprom_cmd_pkg::OFF_CMD, 32'h0002_0000);
        end
        u_eep.nack = 1'b0;
        u_eep.mute = 1'b0;
        u_eep.hog = 1'b0;
        u_eep.stretch = 1'b0;
        u_eep.lat = 20;
        cmd(eeprom_cmd_pkg::CODE_READ, 16'h0005);
        cmd(eeprom_cmd_pkg::CODE_READ, 16'h0007);
        #1;
        chk({16'h0, xfer_addr}, 32'h0005);
        wait_bit(eeprom_cmd_pkg::OFF_CMD, 31, 1'b0);
        rd(eeprom_cmd_pkg::OFF_DATA, v);
        chk(v, 32'h3C);
        u_eep.lat = 2;
        u_eep.mem[0] = 8'hA5;
        u_eep.mem[1] = 8'h02;
        u_eep.mem[2] = 8'h11;
        u_eep.mem[3] = 8'h22;
        cfg_q.delete();
        cmd(eeprom_cmd_pkg::CODE_RELOAD, 16'h0000);
        @(posedge ref_clk);
        #1;
        chk({31'h0, device_ready}, 32'h0);
        wait_bit(eeprom_cmd_pkg::OFF_HARDWARE_CONFIG_REG, 0, 1'b1);
        rd(eeprom_cmd_pkg::OFF_CMD, v);
        chk(v & 32'h8007_0000, 32'h0001_0000);
        chk(32'(cfg_q.size()), 32'h2);
        chk({16'h0, cfg_q[0], cfg_q[1]}, 32'h1122);
        wr(eeprom_cmd_pkg::OFF_CMD, 32'h0);
        rd(eeprom_cmd_pkg::OFF_CMD, v);
        chk(v & 32'h0001_0000, 32'h0001_0000);
        wr(eeprom_cmd_pkg::OFF_CMD, 32'h0001_0000);
        rd(eeprom_cmd_pkg::OFF_CMD, v);
        chk(v & 32'h0001_0000, 32'h0);
        u_eep.mem[0] = 8'h5A;
        cmd(eeprom_cmd_pkg::CODE_RELOAD, 16'h0000);
        wait_bit(eeprom_cmd_pkg::OFF_HARDWARE_CONFIG_REG, 0, 1'b1);
        rd(eeprom_cmd_pkg::OFF_CMD, v);
        chk(v & 32'h8007_0000, 32'h0);
        u_eep.mem[0] = 8'hA5;
        u_eep.mem[1] = 8'h20;
        cmd(eeprom_cmd_pkg::CODE_RELOAD, 16'h0000);
        wait_bit(eeprom_cmd_pkg::OFF_HARDWARE_CONFIG_REG, 0, 1'b1);
        rd(eeprom_cmd_pkg::OFF_CMD, v);
        chk(v & 32'h8005_0000, 32'h0004_0000);
        wr(eeprom_cmd_pkg::OFF_CMD, 32'h0004_0000);
        rd(eeprom_cmd_pkg::OFF_CMD, v);
        chk(v & 32'h0004_0000, 32'h0004_0000);
        wr(eeprom_cmd_pkg::OFF_IRQ_MASK, 32'h0);
        wr(eeprom_cmd_pkg::OFF_IRQ_STAT, 32'hF);
        cmd(eeprom_cmd_pkg::CODE_READ, 16'h0005);
        wait_bit(eeprom_cmd_pkg::OFF_CMD, 31, 1'b0);
        rd(eeprom_cmd_pkg::OFF_IRQ_STAT, v);
        chk(v, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(eeprom_cmd_pkg::OFF_IRQ_MASK, 32'h1);
        rd(eeprom_cmd_pkg::OFF_IRQ_MASK, v);
        chk(v, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(eeprom_cmd_pkg::OFF_IRQ_STAT, 32'h1);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule
